/* tdp_cfg.svh */
// constants for the test and diagnostic port block
`ifndef TDP_CFG_SVH
`define TDP_CFG_SVH
// register bus geometry and map
`define TDP_ADDR_W 8
`define TDP_DATA_W 32
`define TDP_REG_FETCH_CTL 8'h00
`define TDP_CTL_TX_POS 0
`define TDP_CTL_RX_POS 1
`define TDP_CTL_FAIL_POS 23
`define TDP_CTL_TX_RESET 1'b0
// serial rom clock periods in cpu cycles
`define TDP_ROM_PERIOD_SLOW 256
`define TDP_ROM_PERIOD_FAST 16
`define TDP_ROM_DIV_W 8
// status pin timing in cpu cycles
`define TDP_RESULT_LOW_CYC 16
`define TDP_WDOG_CYC 2048
`define TDP_WDOG_PULSE_CYC 3
`define TDP_CNT_W 12
// instruction register
`define TDP_IR_W 5
`define TDP_IR_CAPTURE 5'h01
`define TDP_OP_SAMPLE 5'h18
`define TDP_OP_HIGHZ 5'h19
`define TDP_OP_CLAMP 5'h1a
`define TDP_OP_EXTEST 5'h1b
`define TDP_OP_BYPASS 5'h1f
`endif

/* tdp_pkg.sv */
// types shared by the test and diagnostic port block
`include "tdp_cfg.svh"
package tdp_pkg;
  // power-up sequence phases
  typedef enum logic [2:0] {
    PH_SELFTEST, PH_RESULT, PH_LOAD, PH_RUN
  } tdp_phase_t;
  // boundary-scan controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } tdp_tap_t;
  // register bus request
  typedef struct packed {
    logic [`TDP_ADDR_W-1:0] addr;
    logic [`TDP_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tdp_bus_req_t;
  // controls toward the boundary-scan cell chain
  typedef struct packed {
    logic capture;
    logic shift;
    logic update;
    logic extest;
    logic clamp;
    logic highz;
  } tdp_bsr_ctl_t;
endpackage : tdp_pkg

/* tdp_top.sv */
// test and diagnostic port: serial rom loader, diagnostic uart bits, tap, status pin
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "tdp_cfg.svh"
module tdp_top
  import tdp_pkg::*;
#(
  parameter int LOAD_BITS = 64,
  parameter int SHIFT_W = 32
) (
  // clock and synchronous reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register bus
  input wire tdp_bus_req_t bus_i,
  output logic [`TDP_DATA_W-1:0] rdata_o,
  // core status
  input wire logic selftest_done_i,
  input wire logic selftest_fail_i,
  input wire logic insn_retired_i,
  input wire logic privileged_mode_i,
  input wire logic ext_irq_i,
  input wire logic fast_rom_rate_flag_i,
  output logic irq_o,
  output logic load_done_o,
  output logic [SHIFT_W-1:0] load_data_o,
  // serial rom and terminal pins
  input wire logic rom_data_rx_in_i,
  output logic rom_clock_tx_out_o,
  output logic rom_output_enable_n_o,
  output logic selftest_status_out_o,
  // boundary-scan pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // boundary-scan cell chain
  input wire logic bsr_tdo_i,
  output tdp_bsr_ctl_t bsr_ctl_o
);

  // two-flop synchronisers for pin inputs: data, tck, tms, tdi, trst_n
  localparam int NS = 5;
  logic [NS-1:0] sync1_reg, sync2_reg, sync1_next, sync2_next;
  logic [NS-1:0] pins;
  logic rxd, tck_s, tms_s, tdi_s, trst_n_s;
  logic tck_prev_reg, tck_prev_next;
  logic tck_rise, tck_fall;

  assign pins = {rom_data_rx_in_i, tck_i, tms_i, tdi_i, trst_n_i};
  assign {rxd, tck_s, tms_s, tdi_s, trst_n_s} = sync2_reg;
  assign tck_rise = tck_s & ~tck_prev_reg;
  assign tck_fall = ~tck_s & tck_prev_reg;

  // synchroniser next values
  always_comb begin
    sync1_next = pins;
    sync2_next = sync1_reg;
    tck_prev_next = tck_s;
  end

  // synchroniser registers, trst_n and tck idle high/low respectively
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync1_reg <= 5'h01;
      sync2_reg <= 5'h01;
      tck_prev_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      tck_prev_reg <= tck_prev_next;
    end
  end

  // ---------------- power-up sequence, rom load and status pin ----------------
  tdp_phase_t phase_reg, phase_next;
  logic [`TDP_CNT_W-1:0] cnt_reg, cnt_next; // result timer, later watchdog
  logic [1:0] pulse_reg, pulse_next; // timeout pulse cycles left
  logic fail_reg, fail_next; // self-test outcome
  logic [`TDP_ROM_DIV_W-1:0] div_reg, div_next; // rom clock divider
  logic rclk_reg, rclk_next; // rom clock during load
  logic [15:0] bits_reg, bits_next; // bits loaded
  logic [SHIFT_W-1:0] shift_reg, shift_next; // load shift register
  logic status_reg, status_next;
  logic [`TDP_ROM_DIV_W-1:0] half;

  // half period of the rom clock
  assign half = fast_rom_rate_flag_i ? `TDP_ROM_DIV_W'(`TDP_ROM_PERIOD_FAST / 2)
                                     : `TDP_ROM_DIV_W'(`TDP_ROM_PERIOD_SLOW / 2);

  // sequence next values
  always_comb begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    pulse_next = pulse_reg;
    fail_next = fail_reg;
    div_next = div_reg;
    rclk_next = rclk_reg;
    bits_next = bits_reg;
    shift_next = shift_reg;
    status_next = status_reg;
    unique case (phase_reg)
      PH_SELFTEST: begin
        status_next = 1'b1;
        if (selftest_done_i) begin
          fail_next = selftest_fail_i;
          phase_next = PH_RESULT;
          cnt_next = '0;
          status_next = 1'b0;
        end
      end
      PH_RESULT: begin
        // low for the extraction window, then the fail level
        cnt_next = cnt_reg + 1'b1;
        status_next = 1'b0;
        if (cnt_reg == `TDP_CNT_W'(`TDP_RESULT_LOW_CYC - 1)) begin
          status_next = fail_reg;
          phase_next = PH_LOAD;
          div_next = '0;
          bits_next = '0;
        end
      end
      PH_LOAD: begin
        // free divider, toggle at each half period
        div_next = div_reg + 1'b1;
        if (div_reg == half - 1'b1) begin
          div_next = '0;
          rclk_next = ~rclk_reg;
          if (!rclk_reg) begin
            // rising edge: rom advances, we take its bit
            shift_next = {shift_reg[SHIFT_W-2:0], rxd};
            bits_next = bits_reg + 1'b1;
          end else if (bits_reg == 16'(LOAD_BITS)) begin
            phase_next = PH_RUN; // finish after the last bit's high half
            cnt_next = '0;
          end
        end
      end
      PH_RUN: begin
        // retirement watchdog
        if (insn_retired_i) begin
          cnt_next = '0;
        end else if (cnt_reg == `TDP_CNT_W'(`TDP_WDOG_CYC - 1)) begin
          cnt_next = '0;
          pulse_next = 2'(`TDP_WDOG_PULSE_CYC);
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
        if (pulse_reg != 2'h0) begin
          pulse_next = pulse_reg - 1'b1;
        end
        status_next = fail_reg | (pulse_next != 2'h0);
      end
      default: begin
        phase_next = PH_SELFTEST;
      end
    endcase
  end

  // sequence registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      phase_reg <= PH_SELFTEST;
      cnt_reg <= '0;
      pulse_reg <= 2'h0;
      fail_reg <= 1'b0;
      div_reg <= '0;
      rclk_reg <= 1'b0;
      bits_reg <= '0;
      shift_reg <= '0;
      status_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      pulse_reg <= pulse_next;
      fail_reg <= fail_next;
      div_reg <= div_next;
      rclk_reg <= rclk_next;
      bits_reg <= bits_next;
      shift_reg <= shift_next;
      status_reg <= status_next;
    end
  end

  // ---------------- diagnostic terminal bits and register bus ----------------
  logic tx_pend_reg, tx_pend_next; // written, not yet retired
  logic tx_wait_reg, tx_wait_next; // a write awaits retirement
  logic tx_reg, tx_next; // value on the pin
  logic rx_prev_reg, rx_prev_next;
  logic rx_pend_reg, rx_pend_next; // held while interrupts are blocked
  logic irq_reg, irq_next;
  logic [`TDP_DATA_W-1:0] rdata_reg, rdata_next;
  logic ctl_hit;

  assign ctl_hit = bus_i.addr == `TDP_REG_FETCH_CTL;

  // terminal and bus next values
  always_comb begin
    tx_pend_next = tx_pend_reg;
    tx_wait_next = tx_wait_reg;
    tx_next = tx_reg;
    rx_prev_next = rxd;
    rx_pend_next = rx_pend_reg;
    irq_next = 1'b0;
    rdata_next = '0;
    // the pin takes the value only when the writing instruction retires
    if (tx_wait_reg && insn_retired_i) begin
      tx_next = tx_pend_reg;
      tx_wait_next = 1'b0;
    end
    if (bus_i.wr && ctl_hit) begin
      tx_pend_next = bus_i.wdata[`TDP_CTL_TX_POS];
      tx_wait_next = 1'b1;
    end
    // receive transitions; an edge wins over a clear in the same cycle
    if (!privileged_mode_i) begin
      rx_pend_next = 1'b0;
    end
    if (phase_reg == PH_RUN && rxd != rx_prev_reg) begin
      rx_pend_next = 1'b1;
    end
    if (!privileged_mode_i) begin
      irq_next = rx_pend_reg | ext_irq_i;
    end
    if (bus_i.rd && ctl_hit) begin
      rdata_next[`TDP_CTL_TX_POS] = tx_pend_reg;
      rdata_next[`TDP_CTL_RX_POS] = rxd;
      rdata_next[`TDP_CTL_FAIL_POS] = fail_reg;
    end
  end

  // terminal and bus registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tx_pend_reg <= `TDP_CTL_TX_RESET;
      tx_wait_reg <= 1'b0;
      tx_reg <= `TDP_CTL_TX_RESET;
      rx_prev_reg <= 1'b0;
      rx_pend_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      tx_pend_reg <= tx_pend_next;
      tx_wait_reg <= tx_wait_next;
      tx_reg <= tx_next;
      rx_prev_reg <= rx_prev_next;
      rx_pend_reg <= rx_pend_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  // ---------------- boundary-scan tap ----------------
  tdp_tap_t tap_reg, tap_next, tap_step;
  logic [`TDP_IR_W-1:0] ir_reg, ir_next, irs_reg, irs_next;
  logic byp_reg, byp_next;
  logic tdo_reg, tdo_next, oe_reg, oe_next;
  tdp_bsr_ctl_t bctl_reg, bctl_next;
  logic use_bsr;

  // sample and extest route the cell chain, all else the bypass stage
  assign use_bsr = (ir_reg == `TDP_OP_SAMPLE) || (ir_reg == `TDP_OP_EXTEST);

  // state successor for the sampled mode select level
  always_comb begin
    unique case (tap_reg)
      TAP_RESET: tap_step = tms_s ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_step = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_step = tms_s ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_step = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_step = tms_s ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_step = tms_s ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_step = tms_s ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_step = tms_s ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR: tap_step = tms_s ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_step = tms_s ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_step = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_step = tms_s ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_step = tms_s ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_step = tms_s ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_step = tms_s ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR: tap_step = tms_s ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  // tap next values: shift and capture on tck rise, update and tdo on fall
  always_comb begin
    tap_next = tap_reg;
    ir_next = ir_reg;
    irs_next = irs_reg;
    byp_next = byp_reg;
    tdo_next = tdo_reg;
    oe_next = oe_reg;
    bctl_next = bctl_reg;
    bctl_next.capture = 1'b0;
    bctl_next.shift = 1'b0;
    bctl_next.update = 1'b0;
    if (tck_rise) begin
      tap_next = tap_step;
      unique case (tap_reg)
        TAP_CAP_IR: irs_next = `TDP_IR_CAPTURE;
        TAP_SHIFT_IR: irs_next = {tdi_s, irs_reg[`TDP_IR_W-1:1]};
        TAP_CAP_DR: begin
          byp_next = 1'b0;
          bctl_next.capture = use_bsr;
        end
        TAP_SHIFT_DR: begin
          byp_next = tdi_s;
          bctl_next.shift = use_bsr;
        end
        default: begin
        end
      endcase
    end
    if (tck_fall) begin
      oe_next = (tap_reg == TAP_SHIFT_IR) || (tap_reg == TAP_SHIFT_DR);
      tdo_next = (tap_reg == TAP_SHIFT_IR) ? irs_reg[0] :
                 (use_bsr ? bsr_tdo_i : byp_reg);
      if (tap_reg == TAP_UPD_IR) begin
        ir_next = irs_reg;
        bctl_next.extest = irs_reg == `TDP_OP_EXTEST;
        bctl_next.clamp = irs_reg == `TDP_OP_CLAMP;
        bctl_next.highz = irs_reg == `TDP_OP_HIGHZ;
      end
      bctl_next.update = (tap_reg == TAP_UPD_DR) && use_bsr;
    end
    if (!trst_n_s || tap_reg == TAP_RESET) begin
      // test reset: bypass selected, pins released
      if (!trst_n_s) begin
        tap_next = TAP_RESET;
      end
      ir_next = `TDP_OP_BYPASS;
      oe_next = 1'b0;
      bctl_next = '0;
    end
  end

  // tap registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tap_reg <= TAP_RESET;
      ir_reg <= `TDP_OP_BYPASS;
      irs_reg <= `TDP_IR_CAPTURE;
      byp_reg <= 1'b0;
      tdo_reg <= 1'b0;
      oe_reg <= 1'b0;
      bctl_reg <= '0;
    end else begin
      tap_reg <= tap_next;
      ir_reg <= ir_next;
      irs_reg <= irs_next;
      byp_reg <= byp_next;
      tdo_reg <= tdo_next;
      oe_reg <= oe_next;
      bctl_reg <= bctl_next;
    end
  end

  // outputs
  assign rdata_o = rdata_reg;
  assign irq_o = irq_reg;
  assign load_done_o = phase_reg == PH_RUN;
  assign load_data_o = shift_reg;
  assign rom_clock_tx_out_o = (phase_reg == PH_LOAD) ? rclk_reg : tx_reg;
  assign rom_output_enable_n_o = phase_reg != PH_LOAD;
  assign selftest_status_out_o = status_reg;
  assign tdo_o = tdo_reg;
  assign tdo_oe_o = oe_reg;
  assign bsr_ctl_o = bctl_reg;

endmodule : tdp_top

/* tdp_asserts.sv */
// assertion checker bound to the test and diagnostic port top
`timescale 1ns/1ns
module tdp_asserts
  import tdp_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // watched inputs
  input wire logic selftest_done_i,
  input wire logic selftest_fail_i,
  input wire logic insn_retired_i,
  input wire logic privileged_mode_i,
  input wire logic ext_irq_i,
  input wire logic fast_rom_rate_flag_i,
  input wire logic trst_n_i,
  // watched outputs
  input wire logic irq_o,
  input wire logic load_done_o,
  input wire logic rom_clock_tx_out_o,
  input wire logic rom_output_enable_n_o,
  input wire logic selftest_status_out_o,
  input wire logic tdo_oe_o,
  input wire tdp_bsr_ctl_t bsr_ctl_o
);
  logic rclk_reg; // rom clock level of the last cycle
  logic [11:0] half_reg, half_next; // cycles since the rom clock last moved
  logic [11:0] idle_reg, idle_next; // cycles since the last retire
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // counters restart on a rom clock change or a retire
  always_comb begin
    half_next = (rclk_reg != rom_clock_tx_out_o) ? 12'h000 : half_reg + 12'h001;
    idle_next = insn_retired_i ? 12'h000 : idle_reg + 12'h001;
  end
  // counter registers, cleared in reset
  always_ff @(posedge clk_i) begin
    rclk_reg <= rom_clock_tx_out_o;
    half_reg <= rst_n_i ? half_next : 12'h000;
    idle_reg <= rst_n_i ? idle_next : 12'h000;
  end
  a_load_oe_high: assert property (
    load_done_o |-> rom_output_enable_n_o) else $error("rom enable low after load");
  a_rom_half_per: assert property (
    $fell(rom_clock_tx_out_o) && !rom_output_enable_n_o
    |-> half_reg == (fast_rom_rate_flag_i ? 12'h007 : 12'h07f))
    else $error("rom clock half period wrong");
  a_tx_hold_retire: assert property (
    load_done_o && !insn_retired_i |=> $stable(rom_clock_tx_out_o))
    else $error("tx pin moved without a retire");
  a_status_boot: assert property (
    $rose(rst_n_i) |-> !selftest_status_out_o ##[1:2] selftest_status_out_o)
    else $error("status not low then high after reset");
  a_result_window: assert property (
    selftest_done_i |=> (!selftest_status_out_o)[*8] ##1 (!selftest_status_out_o)[*8]
    ##1 (selftest_status_out_o == $past(selftest_fail_i, 17)))
    else $error("result window wrong");
  a_wdog_start: assert property (
    $rose(selftest_status_out_o) && load_done_o |-> idle_reg inside {[12'h7fe:12'h804]})
    else $error("timeout pulse not after idle count");
  a_wdog_width: assert property (
    $rose(selftest_status_out_o) && load_done_o
    |-> selftest_status_out_o[*3] ##1 !selftest_status_out_o)
    else $error("timeout pulse width wrong");
  a_irq_blocked: assert property (
    privileged_mode_i |=> !irq_o) else $error("irq in privileged mode");
  a_irq_ext_pass: assert property (
    ext_irq_i && !privileged_mode_i |=> irq_o) else $error("irq missing");
  a_trst_clears: assert property (
    (!trst_n_i)[*6] |-> !tdo_oe_o && bsr_ctl_o == 6'h00)
    else $error("test reset did not clear scan logic");
  c_load: cover property ($rose(load_done_o));
  c_irq: cover property ($rose(irq_o));
  c_shift: cover property ($rose(tdo_oe_o));
endmodule : tdp_asserts

bind tdp_top tdp_asserts chk_u (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .selftest_done_i(selftest_done_i),
  .selftest_fail_i(selftest_fail_i), .insn_retired_i(insn_retired_i),
  .privileged_mode_i(privileged_mode_i), .ext_irq_i(ext_irq_i),
  .fast_rom_rate_flag_i(fast_rom_rate_flag_i), .trst_n_i(trst_n_i), .irq_o(irq_o),
  .load_done_o(load_done_o), .rom_clock_tx_out_o(rom_clock_tx_out_o),
  .rom_output_enable_n_o(rom_output_enable_n_o),
  .selftest_status_out_o(selftest_status_out_o), .tdo_oe_o(tdo_oe_o), .bsr_ctl_o(bsr_ctl_o)
);

/* tdp_rom_model.sv */
// serial rom plus terminal driver sharing the rom data line
`timescale 1ns/1ns
module tdp_rom_model #(
  parameter logic [3:0] IMAGE = 4'hb,
  parameter int HOLD_NS = 100
) (
  // rom pins
  input wire logic rom_clk_i,
  input wire logic oe_n_i,
  // terminal level driven while the rom is disabled
  input wire logic term_i,
  output logic data_o
);
  int idx = 3; // bit on the line, first bit first
  // enable high holds the rom at its first bit
  always @(posedge oe_n_i) idx = 3;
  // advance only after the hold time behind each rising clock
  always @(posedge rom_clk_i) if (!oe_n_i) idx = #HOLD_NS idx - 1;
  // past the image the line shows the inverse of the last bit
  assign data_o = oe_n_i ? term_i : (idx >= 0 ? IMAGE[idx[1:0]] : ~IMAGE[0]);
endmodule : tdp_rom_model

/* tb_test_and_diag_port.sv */
// self-checking bench for the test and diagnostic port
`timescale 1ns/1ns
`include "tdp_cfg.svh"
module tb_test_and_diag_port import tdp_pkg::*;;
  localparam logic [3:0] IMG = 4'hb; // rom image
  localparam logic [4:0] OPS [5] = '{`TDP_OP_SAMPLE, `TDP_OP_HIGHZ, `TDP_OP_CLAMP,
    `TDP_OP_EXTEST, `TDP_OP_BYPASS};
  localparam logic [2:0] CTL [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0}; // extest clamp highz
  localparam logic [4:0] DRX [5] = '{5'h12, 5'h1a, 5'h1a, 5'h12, 5'h1a}; // data scan out
  logic clk_i = 1'b0, rst_n_i = 1'b0;
  tdp_bus_req_t bus_i = '0;
  logic done = 1'b0, fail = 1'b0, ret = 1'b1, priv = 1'b0, ext = 1'b0, fast = 1'b0;
  logic term = 1'b1, tck = 1'b0, tms = 1'b1, tdi = 1'b0, trst_n = 1'b0;
  logic [31:0] rdata, load_data;
  logic irq, ldone, rclk, oe_n, stat, tdo, oe, rom_d, bsr_tdo;
  tdp_bsr_ctl_t bsr;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_pulse = 0; // chain control pulses seen so far
  always #20 clk_i = ~clk_i;
  tdp_top #(.LOAD_BITS(4), .SHIFT_W(32)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata),
    .selftest_done_i(done), .selftest_fail_i(fail), .insn_retired_i(ret),
    .privileged_mode_i(priv), .ext_irq_i(ext), .fast_rom_rate_flag_i(fast),
    .irq_o(irq), .load_done_o(ldone), .load_data_o(load_data),
    .rom_data_rx_in_i(rom_d), .rom_clock_tx_out_o(rclk),
    .rom_output_enable_n_o(oe_n), .selftest_status_out_o(stat),
    .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo),
    .tdo_oe_o(oe), .bsr_tdo_i(bsr_tdo), .bsr_ctl_o(bsr));
  tdp_rom_model #(.IMAGE(IMG), .HOLD_NS(100)) rom_u (
    .rom_clk_i(rclk), .oe_n_i(oe_n), .term_i(term), .data_o(rom_d));
  // cell chain stand-in: returns the inverse of the test data pin
  assign bsr_tdo = ~tdi;
  // count capture, shift and update pulses toward the cell chain
  always @(posedge clk_i) if (bsr.capture || bsr.shift || bsr.update) n_pulse++;
  // verdict and end of run
  task automatic stop_test();
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  function automatic logic sig(input int k);
    case (k)
      0: return oe_n;
      1: return ldone;
      2: return rclk;
      3: return stat;
      default: return irq;
    endcase
  endfunction : sig
  // bounded wait for a level, returns the cycles spent
  task automatic wait_lv(input int k, input logic v, input int lim, output int n);
    n = 0;
    while (sig(k) !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= lim) begin
      n_mismatch++;
      stop_test();
    end
  endtask : wait_lv
  // register bus write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    @(negedge clk_i);
    d = rdata;
  endtask : rd
  // one test clock period of 8 cpu cycles, tdo taken late in the high half
  task automatic tstep(input logic m, input logic d, output logic o);
    @(posedge clk_i);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    cyc(4);
    tck <= 1'b1;
    cyc(3);
    @(negedge clk_i);
    o = tdo;
  endtask : tstep
  // five-bit scan of the instruction or data path, ending in idle
  task automatic scan(input logic ir, input logic [4:0] din, output logic [4:0] got);
    logic o;
    tstep(1'b0, 1'b0, o);
    tstep(1'b1, 1'b0, o);
    if (ir) tstep(1'b1, 1'b0, o);
    tstep(1'b0, 1'b0, o);
    tstep(1'b0, 1'b0, o);
    for (int i = 0; i < 5; i++) begin
      tstep(i == 4, din[i], o);
      got[i] = o;
      check(oe, 1'b1);
    end
    tstep(1'b1, 1'b0, o);
    tstep(1'b0, 1'b0, o);
    check(oe, 1'b0);
  endtask : scan
  // reset, self-test result window and serial rom load
  task automatic t_boot(input logic f, input logic fs);
    int n, m;
    logic [31:0] d;
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    fail <= f;
    fast <= fs;
    cyc(4);
    check(stat, 1'b0);
    rst_n_i <= 1'b1;
    cyc(10);
    check(stat, 1'b1);
    check(oe_n, 1'b1);
    done <= 1'b1;
    cyc(1);
    done <= 1'b0;
    cyc(8);
    check(stat, 1'b0);
    wait_lv(0, 1'b0, 40, n);
    wait_lv(2, 1'b1, 300, n);
    check(stat, f);
    wait_lv(2, 1'b0, 300, n);
    wait_lv(2, 1'b1, 300, m);
    check(n + m, fs ? 16 : 256);
    wait_lv(1, 1'b1, 2000, n);
    check(oe_n, 1'b1);
    check(rclk, 1'b0);
    check(load_data[3:0], IMG);
    rd(8'h00, d);
    check(d[23], f);
  endtask : t_boot
  // transmit bit waits for a retire; unmapped place ignored
  task automatic t_tx();
    logic [31:0] d;
    @(posedge clk_i);
    ret <= 1'b0;
    wr(8'h00, 32'h0000_0001);
    cyc(4);
    check(rclk, 1'b0);
    wr(8'h04, 32'hffff_ffff);
    rd(8'h04, d);
    check(d, 32'h0000_0000);
    rd(8'h00, d);
    check(d, 32'h0000_0003);
    @(posedge clk_i);
    ret <= 1'b1;
    cyc(3);
    check(rclk, 1'b1);
  endtask : t_tx
  // receive edge held while privileged, then trapped
  task automatic t_rx();
    int n;
    logic [31:0] d;
    @(posedge clk_i);
    priv <= 1'b1;
    cyc(2);
    term <= 1'b0;
    cyc(8);
    check(irq, 1'b0);
    rd(8'h00, d);
    check(d[1], 1'b0);
    @(posedge clk_i);
    priv <= 1'b0;
    wait_lv(4, 1'b1, 4, n);
    cyc(3);
    check(irq, 1'b0);
    ext <= 1'b1;
    cyc(3);
    check(irq, 1'b1);
    ext <= 1'b0;
  endtask : t_rx
  // no retire for the timeout count gives a three-cycle pulse
  task automatic t_wdog();
    int n;
    @(posedge clk_i);
    ret <= 1'b0;
    wait_lv(3, 1'b1, 2200, n);
    check(n >= 2046 && n <= 2052, 1'b1);
    wait_lv(3, 1'b0, 8, n);
    check(n, 3);
    ret <= 1'b1;
  endtask : t_wdog
  // every public opcode, its data path, then test reset
  task automatic t_tap();
    logic [4:0] got;
    int p0;
    @(posedge clk_i);
    trst_n <= 1'b1;
    cyc(4);
    for (int k = 0; k < 5; k++) begin
      scan(1'b1, OPS[k], got);
      check(got, 5'h01);
      check(bsr[2:0], CTL[k]);
      p0 = n_pulse;
      scan(1'b0, 5'h0d, got);
      check(got, DRX[k]);
      check(n_pulse - p0, (DRX[k] == 5'h12) ? 7 : 0);
    end
    scan(1'b1, `TDP_OP_EXTEST, got);
    @(posedge clk_i);
    trst_n <= 1'b0;
    cyc(8);
    check(bsr, 6'h00);
    trst_n <= 1'b1;
    cyc(4);
    scan(1'b0, 5'h0d, got);
    check(got, 5'h1a);
  endtask : t_tap
  initial begin
    t_boot(1'b0, 1'b0);
    t_tx();
    t_rx();
    t_wdog();
    t_tap();
    t_boot(1'b1, 1'b1);
    stop_test();
  end
endmodule : tb_test_and_diag_port
